// >>> design/dvp_defines.vh
/*
 * register map, field positions, reset values and encodings of the playback
 * attenuation and pad configuration register bank.
 * assumes the including file adds no prefix of its own to these names.
 */
// Notes on behaviour
// RL1: the left playback code attenuates by 0.375 dB per count, 0x00 is 0 dB and 0xff is -95.625 dB.
// RL2: the right playback code is separate from the left and uses the same 0.375 dB per count scale.
// RL3: after a write the applied attenuation moves one step per audio frame toward the new code, never jumping.
// RL4: a pull field of 00 selects pull-up, 10 no pull, 11 pull-down, and 01 is reserved.
// RL5: serial pad pull fields sit at record out [7:6], playback in [5:4], frame clock [3:2], bit clock [1:0].
// RL6: control pad pull fields sit at data in [7:6], latch [5:4], clock [3:2], data out [1:0].
// RL7: each drive bit selects low drive at 0 and high drive at 1, and goes to its pad.
// RL8: serial drive bits sit at record out 3, playback in 2, frame clock 1, bit clock 0, with [7:4] reserved.
// RL9: reset loads every field with its default column value, control latch pull resetting to pull-up.
`ifndef DVP_DEFINES_VH
`define DVP_DEFINES_VH

`define DVP_ADDR_W          16
`define DVP_ADDR_LEFT_ATT   16'h402b
`define DVP_ADDR_RIGHT_ATT  16'h402c
`define DVP_ADDR_SER_PULL   16'h402d
`define DVP_ADDR_SER_DRIVE  16'h402e
`define DVP_ADDR_CTL_PULL   16'h402f
`define DVP_ADDR_ATT_STATUS 16'h40f0

`define DVP_RST_ATT         8'h00
`define DVP_RST_SER_PULL    8'hff
`define DVP_RST_SER_DRIVE   4'h0
`define DVP_RST_CTL_PULL    8'hcf

`define DVP_PULL_UP         2'h0
`define DVP_PULL_RSVD       2'h1
`define DVP_PULL_NONE       2'h2
`define DVP_PULL_DOWN       2'h3

`define DVP_FLD_HI_MSB      7
`define DVP_FLD_HI_LSB      6
`define DVP_FLD_MH_MSB      5
`define DVP_FLD_MH_LSB      4
`define DVP_FLD_ML_MSB      3
`define DVP_FLD_ML_LSB      2
`define DVP_FLD_LO_MSB      1
`define DVP_FLD_LO_LSB      0
`define DVP_DRV_W           4

`endif

// >>> design/dvp_att_ramp.v
/*
 * one attenuation slew: holds the applied code and steps it one count
 * toward the target on each audio frame pulse.
 * assumes frame_tick_in is a one-cycle pulse on ref_clk_in.
 */
`timescale 1ns/1ps
module dvp_att_ramp #(
    parameter W = 8
) (
    // clock and reset
    input  wire         ref_clk_in,
    input  wire         rst_b_in,
    // control
    input  wire         frame_tick_in,
    input  wire [W-1:0] target_in,
    // state
    output reg  [W-1:0] applied_out,
    output wire         busy_out
);

    assign busy_out = (applied_out != target_in);

    always @(posedge ref_clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
            applied_out <= {W{1'b0}};
        else if (frame_tick_in && busy_out)
        begin
            // one count per frame, so a jump becomes a ramp
            if (applied_out < target_in)
                applied_out <= applied_out + {{(W-1){1'b0}}, 1'b1}; // RL3
            else
                applied_out <= applied_out - {{(W-1){1'b0}}, 1'b1}; // RL3
        end
    end

endmodule

// >>> design/dvp_pull_decode.v
/*
 * decodes N packed 2-bit pad pull fields into pull-up and pull-down enables.
 * assumes the pad treats both enables low as no pull.
 */
`timescale 1ns/1ps
module dvp_pull_decode #(
    parameter N = 4
) (
    // packed fields, field 0 in the low bits
    input  wire [2*N-1:0] sel_in,
    // pad controls
    output wire [N-1:0]   pull_up_out,
    output wire [N-1:0]   pull_dn_out
);

`include "dvp_defines.vh"

    genvar i;
    generate
        for (i = 0; i < N; i = i + 1)
        begin : g_fld
            // reserved code 01 enables nothing, safer than guessing
            assign pull_up_out[i] = (sel_in[2*i+1:2*i] == `DVP_PULL_UP);   // RL4
            assign pull_dn_out[i] = (sel_in[2*i+1:2*i] == `DVP_PULL_DOWN); // RL4
        end
    endgenerate

endmodule

// >>> design/dvp_regs.v
/*
 * register bank for playback attenuation and pad configuration, with
 * frame-stepped attenuation slew and decoded pad controls.
 * assumes a plain strobe register port on ref_clk_in and an audio frame
 * pulse generated on the same clock.
 */
`timescale 1ns/1ps
`include "dvp_defines.vh"
module dvp_regs #(
    parameter ATT_W = 8
) (
    // clock and reset
    input  wire                   ref_clk_in,
    input  wire                   rst_b_in,
    // register port
    input  wire [`DVP_ADDR_W-1:0] addr_in,
    input  wire [7:0]             wdata_in,
    input  wire                   wr_in,
    input  wire                   rd_in,
    output reg  [7:0]             rdata_out,
    // audio frame pulse
    input  wire                   frame_tick_in,
    // applied attenuation codes
    output wire [ATT_W-1:0]       left_att_out,
    output wire [ATT_W-1:0]       right_att_out,
    output wire                   att_busy_out,
    // serial pads: 3 record out, 2 playback in, 1 frame clock, 0 bit clock
    output wire [3:0]             ser_pull_up_out,
    output wire [3:0]             ser_pull_dn_out,
    output wire [3:0]             ser_drive_high_out,
    // control pads: 3 data in, 2 latch, 1 clock, 0 data out
    output wire [3:0]             ctl_pull_up_out,
    output wire [3:0]             ctl_pull_dn_out
);

    reg  [ATT_W-1:0]      left_att_q;
    reg  [ATT_W-1:0]      right_att_q;
    reg  [7:0]            ser_pull_q;
    reg  [`DVP_DRV_W-1:0] ser_drive_q;
    reg  [7:0]            ctl_pull_q;
    reg  [7:0]            rdata_d;
    wire                  left_busy;
    wire                  right_busy;

    function hit;
        input [`DVP_ADDR_W-1:0] a;
        input [`DVP_ADDR_W-1:0] ref_a;
        begin
            hit = (a == ref_a);
        end
    endfunction

    // fields kept in register order so field 3 is the high pair
    function [7:0] fields;
        input [7:0] r;
        begin
            fields = {r[`DVP_FLD_HI_MSB:`DVP_FLD_HI_LSB], r[`DVP_FLD_MH_MSB:`DVP_FLD_MH_LSB],
                      r[`DVP_FLD_ML_MSB:`DVP_FLD_ML_LSB], r[`DVP_FLD_LO_MSB:`DVP_FLD_LO_LSB]};
        end
    endfunction

    always @(posedge ref_clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            left_att_q  <= `DVP_RST_ATT;      // RL9
            right_att_q <= `DVP_RST_ATT;      // RL9
            ser_pull_q  <= `DVP_RST_SER_PULL;  // RL9
            ser_drive_q <= `DVP_RST_SER_DRIVE; // RL9
            ctl_pull_q  <= `DVP_RST_CTL_PULL;  // RL9
        end
        else if (wr_in)
        begin
            if (hit(addr_in, `DVP_ADDR_LEFT_ATT))
                left_att_q <= wdata_in[ATT_W-1:0];  // RL1
            if (hit(addr_in, `DVP_ADDR_RIGHT_ATT))
                right_att_q <= wdata_in[ATT_W-1:0]; // RL2
            if (hit(addr_in, `DVP_ADDR_SER_PULL))
                ser_pull_q <= wdata_in;             // RL5
            if (hit(addr_in, `DVP_ADDR_SER_DRIVE))
                ser_drive_q <= wdata_in[`DVP_DRV_W-1:0]; // RL8
            if (hit(addr_in, `DVP_ADDR_CTL_PULL))
                ctl_pull_q <= wdata_in;             // RL6
        end
    end

    always @*
    begin
        rdata_d = 8'h00;
        if (hit(addr_in, `DVP_ADDR_LEFT_ATT))
            rdata_d = left_att_q;
        else if (hit(addr_in, `DVP_ADDR_RIGHT_ATT))
            rdata_d = right_att_q;
        else if (hit(addr_in, `DVP_ADDR_SER_PULL))
            rdata_d = ser_pull_q;
        else if (hit(addr_in, `DVP_ADDR_SER_DRIVE))
            rdata_d = {4'h0, ser_drive_q}; // RL8
        else if (hit(addr_in, `DVP_ADDR_CTL_PULL))
            rdata_d = ctl_pull_q;
        else if (hit(addr_in, `DVP_ADDR_ATT_STATUS))
            rdata_d = {6'h00, right_busy, left_busy};
    end

    // read data holds only in the cycle after the strobe
    always @(posedge ref_clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
            rdata_out <= 8'h00;
        else if (rd_in)
            rdata_out <= rdata_d;
        else
            rdata_out <= 8'h00;
    end

    dvp_att_ramp #(
        .W (ATT_W)
    ) u_left (
        .ref_clk_in    (ref_clk_in),
        .rst_b_in      (rst_b_in),
        .frame_tick_in (frame_tick_in),
        .target_in     (left_att_q),
        .applied_out   (left_att_out),
        .busy_out      (left_busy)
    );

    dvp_att_ramp #(
        .W (ATT_W)
    ) u_right (
        .ref_clk_in    (ref_clk_in),
        .rst_b_in      (rst_b_in),
        .frame_tick_in (frame_tick_in),
        .target_in     (right_att_q),
        .applied_out   (right_att_out),
        .busy_out      (right_busy)
    );

    assign att_busy_out = left_busy | right_busy;

    assign ser_drive_high_out = ser_drive_q; // RL7

    dvp_pull_decode #(
        .N (4)
    ) u_ser_pull (
        .sel_in      (fields(ser_pull_q)),
        .pull_up_out (ser_pull_up_out),
        .pull_dn_out (ser_pull_dn_out)
    );

    dvp_pull_decode #(
        .N (4)
    ) u_ctl_pull (
        .sel_in      (fields(ctl_pull_q)),
        .pull_up_out (ctl_pull_up_out),
        .pull_dn_out (ctl_pull_dn_out)
    );

endmodule

// >>> dv/dvp_regs_asserts.sv
/* port relations of the dvp_regs bank.
   assumes binding to dvp_regs; only its ports are seen. */
`timescale 1ns/1ps
`include "dvp_defines.vh"
module dvp_regs_chk #(
    parameter ATT_W = 8
) (
    // all ports of dvp_regs
    input wire                   ref_clk_in,
    input wire                   rst_b_in,
    input wire [`DVP_ADDR_W-1:0] addr_in,
    input wire [7:0]             wdata_in,
    input wire                   wr_in,
    input wire                   rd_in,
    input wire [7:0]             rdata_out,
    input wire                   frame_tick_in,
    input wire [ATT_W-1:0]       left_att_out,
    input wire [ATT_W-1:0]       right_att_out,
    input wire                   att_busy_out,
    input wire [3:0]             ser_pull_up_out,
    input wire [3:0]             ser_pull_dn_out,
    input wire [3:0]             ser_drive_high_out,
    input wire [3:0]             ctl_pull_up_out,
    input wire [3:0]             ctl_pull_dn_out
);
    function automatic [3:0] f_is(input [7:0] v, input [1:0] c);
        f_is = {v[7:6] == c, v[5:4] == c, v[3:2] == c, v[1:0] == c};
    endfunction
    sequence s_wr_at(a);
        wr_in && addr_in == a;
    endsequence
    default clocking @(posedge ref_clk_in); endclocking
    default disable iff (!rst_b_in);
    rd_idle_a: assert property (!$past(rd_in) |-> rdata_out == 8'h00) else $error("read data not zero when idle");
    unmapped_rd_a: assert property (rd_in && !(addr_in inside {[16'h402b:16'h402f], 16'h40f0}) |=> rdata_out == 8'h00)
        else $error("unmapped read not zero");
    ser_pull_a: assert property (s_wr_at(`DVP_ADDR_SER_PULL) |=> ser_pull_up_out == f_is($past(wdata_in), 2'h0)
        && ser_pull_dn_out == f_is($past(wdata_in), 2'h3)) else $error("serial pull decode wrong");
    ctl_pull_a: assert property (s_wr_at(`DVP_ADDR_CTL_PULL) |=> ctl_pull_up_out == f_is($past(wdata_in), 2'h0)
        && ctl_pull_dn_out == f_is($past(wdata_in), 2'h3)) else $error("control pull decode wrong");
    drive_bits_a: assert property (s_wr_at(`DVP_ADDR_SER_DRIVE) |=> ser_drive_high_out == $past(wdata_in[3:0]))
        else $error("drive bits wrong");
    drive_rsvd_a: assert property (rd_in && addr_in == `DVP_ADDR_SER_DRIVE |=> rdata_out[7:4] == 4'h0)
        else $error("drive reserved bits not zero");
    left_step_a: assert property (left_att_out != $past(left_att_out) |-> $past(frame_tick_in)
        && (left_att_out == $past(left_att_out) + 1'b1 || left_att_out + 1'b1 == $past(left_att_out)))
        else $error("left slew not one step per frame");
    right_step_a: assert property (right_att_out != $past(right_att_out) |-> $past(frame_tick_in)
        && (right_att_out == $past(right_att_out) + 1'b1 || right_att_out + 1'b1 == $past(right_att_out)))
        else $error("right slew not one step per frame");
    idle_hold_a: assert property (!att_busy_out && !wr_in |=> $stable(left_att_out) && $stable(right_att_out))
        else $error("applied code moved while idle");
endmodule
bind dvp_regs dvp_regs_chk #(.ATT_W(ATT_W)) u_chk (.ref_clk_in(ref_clk_in), .rst_b_in(rst_b_in),
    .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
    .frame_tick_in(frame_tick_in), .left_att_out(left_att_out), .right_att_out(right_att_out),
    .att_busy_out(att_busy_out), .ser_pull_up_out(ser_pull_up_out), .ser_pull_dn_out(ser_pull_dn_out),
    .ser_drive_high_out(ser_drive_high_out), .ctl_pull_up_out(ctl_pull_up_out), .ctl_pull_dn_out(ctl_pull_dn_out));

// >>> dv/dvp_regs_tb.sv
/* self-checking bench for dvp_regs: reset values, pad decode, slew.
   assumes the defines header is on the include path. */
`timescale 1ns/1ps
`include "dvp_defines.vh"
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin num_errors++; \
    $display("mismatch %s expected %h seen %h", nm, e, g); end end
module dvp_regs_tb;
    reg        ref_clk_in = 1'b0;
    reg        rst_b_in = 1'b0;
    reg [15:0] addr_in = 16'h0000;
    reg [7:0]  wdata_in = 8'h00;
    reg        wr_in = 1'b0;
    reg        rd_in = 1'b0;
    reg        frame_tick_in = 1'b0;
    wire [7:0] rdata_out, left_att_out, right_att_out;
    wire       att_busy_out;
    wire [3:0] s_up, s_dn, s_drv, c_up, c_dn;
    int        num_errors = 0;
    int        total_checks = 0;
    int        i;
    always #2.5 ref_clk_in = ~ref_clk_in;
    dvp_regs #(.ATT_W(8)) dut (.ref_clk_in(ref_clk_in), .rst_b_in(rst_b_in), .addr_in(addr_in),
        .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .frame_tick_in(frame_tick_in),
        .left_att_out(left_att_out), .right_att_out(right_att_out), .att_busy_out(att_busy_out),
        .ser_pull_up_out(s_up), .ser_pull_dn_out(s_dn), .ser_drive_high_out(s_drv),
        .ctl_pull_up_out(c_up), .ctl_pull_dn_out(c_dn));
    task wr(input [15:0] a, input [7:0] d);
        @(posedge ref_clk_in);
        wr_in <= 1'b1;
        addr_in <= a;
        wdata_in <= d;
        @(posedge ref_clk_in);
        wr_in <= 1'b0;
        #1;
    endtask
    // read data stand only in the cycle after the strobe
    task rd(input [15:0] a, input [7:0] e);
        @(posedge ref_clk_in);
        rd_in <= 1'b1;
        addr_in <= a;
        @(posedge ref_clk_in);
        rd_in <= 1'b0;
        #1 `CHK("rdata", e, rdata_out)
    endtask
    task tick;
        @(posedge ref_clk_in);
        frame_tick_in <= 1'b1;
        @(posedge ref_clk_in);
        frame_tick_in <= 1'b0;
        #1;
    endtask
    task reset_and_check;
        rst_b_in <= 1'b0;
        repeat (8) @(posedge ref_clk_in);
        rst_b_in <= 1'b1;
        rd(`DVP_ADDR_LEFT_ATT, 8'h00);
        rd(`DVP_ADDR_RIGHT_ATT, 8'h00);
        rd(`DVP_ADDR_SER_PULL, 8'hff);
        rd(`DVP_ADDR_SER_DRIVE, 8'h00);
        rd(`DVP_ADDR_CTL_PULL, 8'hcf);
        `CHK("pads", 16'h0f04, {s_up, s_dn, s_drv, c_up})
        `CHK("att_rst", 17'h00000, {att_busy_out, left_att_out, right_att_out})
        `CHK("ctl_dn", 4'hb, c_dn)
        $display("test reset done");
    endtask
    task give_verdict;
        $display("checks %0d mismatches %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    initial
    begin
        #40000;
        num_errors++;
        give_verdict;
    end
    initial
    begin
        reset_and_check;
        for (i = 0; i < 4; i++)
        begin
            wr(`DVP_ADDR_SER_PULL, {4{i[1:0]}});
            `CHK("pull_codes", {{4{i[1:0] == 2'h0}}, {4{i[1:0] == 2'h3}}}, {s_up, s_dn})
        end
        wr(`DVP_ADDR_SER_PULL, 8'h2d);
        `CHK("ser_fields", 8'h82, {s_up, s_dn})
        wr(`DVP_ADDR_CTL_PULL, 8'hc8);
        `CHK("ctl_fields", 8'h58, {c_up, c_dn})
        wr(`DVP_ADDR_SER_DRIVE, 8'hf5);
        `CHK("drive", 4'h5, s_drv)
        rd(`DVP_ADDR_SER_DRIVE, 8'h05);
        wr(16'h4030, 8'h5a);
        rd(16'h4030, 8'h00);
        rd(`DVP_ADDR_SER_PULL, 8'h2d);
        $display("test pads done");
        wr(`DVP_ADDR_LEFT_ATT, 8'h03);
        `CHK("busy", 9'h100, {att_busy_out, left_att_out})
        for (i = 1; i < 5; i++)
        begin
            tick;
            `CHK("left_up", (i > 3) ? 16'h0300 : {i[7:0], 8'h00}, {left_att_out, right_att_out})
        end
        `CHK("idle", 1'b0, att_busy_out)
        rd(`DVP_ADDR_LEFT_ATT, 8'h03);
        wr(`DVP_ADDR_LEFT_ATT, 8'h01);
        tick;
        tick;
        `CHK("left_down", 8'h01, left_att_out)
        wr(`DVP_ADDR_RIGHT_ATT, 8'hff);
        rd(`DVP_ADDR_ATT_STATUS, 8'h02);
        for (i = 1; i < 257; i++)
        begin
            tick;
            `CHK("right_ramp", (i > 255) ? 8'hff : i[7:0], right_att_out)
        end
        `CHK("left_kept", 8'h01, left_att_out)
        $display("test slew done");
        reset_and_check;
        give_verdict;
    end
endmodule
